// [inc/capseq_defs.svh]
// Constants shared by both ends of the capture sequencer link.
`ifndef CAPSEQ_DEFS_SVH
`define CAPSEQ_DEFS_SVH
`define PRV_DIM 6'd24
`define FULL_DIM 6'd48
`define ZONES 3'd5
`define BLANK_CYC 6'd40
`define SNAP_MAX_FRAMES 4'd10
`define DIV_STEPS 5'd22
`define EXP_T_RST 8'd100
`define EXP_T_MIN 8'd4
`define EXP_T_MAX 8'd200
`define AE_T_STEP 8'd4
`define AGAIN_RST 4'd1
`define AGAIN_MAX 4'd15
`define DGAIN_UNITY 5'h10
`define DGAIN_MAX 5'h1f
`define TARGET_RST 8'h80
`define THRESH_RST 8'h08
`define SPEED_RST 2'd2
`define SETTLE_RST 4'd3
`define W_CTR 3'd4
`define W_MID 3'd2
`define W_ONE 3'd1
`define A_CMD 8'h00
`define A_STAT 8'h04
`define A_RIDX 8'h08
`define A_RDAT 8'h0c
`define CMD_OP_LSB 16
`define RING_AW 3
`endif

// [inc/capseq_pkg.sv]
// Types shared by both ends of the capture sequencer link.
package capseq_pkg;
    typedef enum logic [2:0] {OP_CTX, OP_TARGET, OP_THRESH, OP_SPEED, OP_CAPCFG, OP_WINDOW,
        OP_WEIGHT, OP_FLASH} cmd_op_t;
    typedef enum logic [1:0] {CAP_SNAP, CAP_VIDEO, CAP_BATCH} cap_mode_t;
    typedef enum logic [1:0] {WM_FLAT, WM_CENTRE, WM_EDGE} weight_mode_t;
    typedef enum {SQ_PREVIEW, SQ_SETTLE, SQ_CAPTURE, SQ_VIDEO, SQ_BATCH} seq_state_t;
    typedef enum {AE_ACC, AE_DIV, AE_UPD} ae_phase_t;
endpackage

// [inc/capseq_if.sv]
// Command and pixel link between host controller and sensor sequencer.
`timescale 1ns/100ps
interface capseq_if;
    logic cmd_valid;
    capseq_pkg::cmd_op_t cmd_op;
    logic [15:0] cmd_data;
    logic cmd_ack;
    logic fs;
    logic pvalid;
    logic [7:0] pdata;
    logic ctx_b;
    modport dev (input cmd_valid, input cmd_op, input cmd_data, output cmd_ack,
        output fs, output pvalid, output pdata, output ctx_b);
    modport host (output cmd_valid, output cmd_op, output cmd_data, input cmd_ack,
        input fs, input pvalid, input pdata, input ctx_b);
endinterface

// [rtl/capseq_dev.sv]
// Sensor end: context sequencer, frame generator and exposure control.
//
// Notes on behaviour
// - Host requests snapshot by context change command.
// - LED flash on, exposure settles, then capture.
// - Capture frames at set size, xenon strobes.
// - Return to preview alone after last frame.
// - Snapshot sequence lasts at most ten frames.
// - Host sets capture settings before video command.
// - Video applies new settings, streams without gap.
// - Another context change leaves video to preview.
// - Host keeps batch frames in ring buffer.
// - Exposure adjusts time, analog and digital gain.
// - Statistics over five by five zone grid.
// - Brightness tracks target via gain and time.
// - Zone weighting selectable, window offset movable.
// - Exposure runs in preview, optionally in video.
// - Backlight mode weights centre zones higher.
// - Time filter, speed and threshold controls.
// - Host may reprogram parameters, defaults otherwise.
// - Context changes travel as commands on link.
// - Preview is small, fast, fully automatic.
`timescale 1ns/100ps
`include "capseq_defs.svh"
module capseq_dev (
    input wire logic clk,
    input wire logic rst,
    capseq_if.dev lnk,
    input wire logic [7:0] sensor_luma,
    output logic sensor_read,
    output logic led_flash,
    output logic xenon_strobe,
    output logic [7:0] exp_time,
    output logic [3:0] analog_gain,
    output logic [4:0] digital_gain,
    output logic seq_busy
);
    import capseq_pkg::*;

    // Returns {inside, zone index} for one axis of the statistics window.
    function automatic logic [3:0] zone_of(input logic [5:0] pos, input logic [2:0] off,
        input logic full);
        logic [5:0] rel;
        logic [5:0] z;
        rel = pos - {3'b000, off};
        z = full ? (rel >> 3) : (rel >> 2);
        zone_of = {(pos >= {3'b000, off}) && (z < {3'b000, `ZONES}), z[2:0]};
    endfunction

    function automatic logic [2:0] weight_of(input weight_mode_t m, input logic [2:0] c,
        input logic [2:0] r);
        logic edge_z;
        logic ctr;
        edge_z = (c == 3'd0) || (c == 3'd4) || (r == 3'd0) || (r == 3'd4);
        ctr = (c == 3'd2) && (r == 3'd2);
        if (m == WM_CENTRE)
            weight_of = ctr ? `W_CTR : (edge_z ? `W_ONE : `W_MID);
        else if (m == WM_EDGE)
            weight_of = edge_z ? `W_MID : `W_ONE;
        else
            weight_of = `W_ONE;
    endfunction

    // Configuration written by the host.
    logic [7:0] target_q, target_d, thresh_q, thresh_d;
    logic [1:0] speed_q, speed_d;
    logic [7:0] capcfg_q, capcfg_d, act_cap_q, act_cap_d;
    logic [5:0] win_q, win_d;
    weight_mode_t wmode_q, wmode_d;
    logic [6:0] flash_q, flash_d;
    logic ack_q, ack_d;
    logic accept;
    logic ctx_cmd;

    assign accept = lnk.cmd_valid && !ack_q;
    assign ctx_cmd = accept && (lnk.cmd_op == OP_CTX);

    always_comb
    begin
        target_d = target_q;
        thresh_d = thresh_q;
        speed_d = speed_q;
        capcfg_d = capcfg_q;
        win_d = win_q;
        wmode_d = wmode_q;
        flash_d = flash_q;
        ack_d = accept;
        if (accept)
        begin
            unique case (lnk.cmd_op)
                OP_TARGET: target_d = lnk.cmd_data[7:0];
                OP_THRESH: thresh_d = lnk.cmd_data[7:0];
                OP_SPEED: speed_d = lnk.cmd_data[1:0];
                OP_CAPCFG: capcfg_d = lnk.cmd_data[7:0];
                OP_WINDOW: win_d = lnk.cmd_data[5:0];
                OP_WEIGHT: wmode_d = weight_mode_t'(lnk.cmd_data[1:0]);
                OP_FLASH: flash_d = lnk.cmd_data[6:0];
                OP_CTX: ack_d = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            target_q <= `TARGET_RST;
            thresh_q <= `THRESH_RST;
            speed_q <= `SPEED_RST;
            capcfg_q <= 8'h00;
            win_q <= 6'h00;
            wmode_q <= WM_CENTRE;
            flash_q <= {`SETTLE_RST, 3'b000};
            ack_q <= 1'b0;
        end
        else
        begin
            target_q <= target_d;
            thresh_q <= thresh_d;
            speed_q <= speed_d;
            capcfg_q <= capcfg_d;
            win_q <= win_d;
            wmode_q <= wmode_d;
            flash_q <= flash_d;
            ack_q <= ack_d;
        end
    end

    // Frame generator signals used by the sequencer and exposure control.
    logic active_q, active_d;
    logic [5:0] px_q, px_d, py_q, py_d, bl_q, bl_d;
    logic full_q, full_d;
    logic fb;
    logic eof;
    logic [5:0] dim;
    assign dim = full_q ? `FULL_DIM : `PRV_DIM;
    assign fb = !active_q && (bl_q == `BLANK_CYC - 6'd1);
    assign eof = active_q && (px_q == dim - 6'd1) && (py_q == dim - 6'd1);

    // Sequencer.
    seq_state_t seq_q, seq_d;
    logic [3:0] fcnt_q, fcnt_d, seqf_q, seqf_d;
    logic flash_use;
    assign flash_use = flash_q[2];

    always_comb
    begin
        seq_d = seq_q;
        fcnt_d = fcnt_q;
        seqf_d = (fb && seq_q != SQ_PREVIEW) ? seqf_q + 4'd1 : seqf_q;
        act_cap_d = act_cap_q;
        unique case (seq_q)
            SQ_PREVIEW:
                if (ctx_cmd)
                begin
                    act_cap_d = capcfg_q;
                    fcnt_d = 4'd0;
                    seqf_d = 4'd0;
                    if (capcfg_q[1:0] == CAP_VIDEO)
                        seq_d = SQ_VIDEO;
                    else if (capcfg_q[1:0] == CAP_BATCH)
                        seq_d = SQ_BATCH;
                    else if (flash_q[0] && flash_use)
                        seq_d = SQ_SETTLE;
                    else
                        seq_d = SQ_CAPTURE;
                end
            SQ_SETTLE:
                if (fb)
                begin
                    fcnt_d = fcnt_q + 4'd1;
                    // The frame started here is already the first capture frame.
                    if (fcnt_q >= flash_q[6:3] || seqf_q + 4'd1 >= `SNAP_MAX_FRAMES - 4'd2)
                    begin
                        seq_d = SQ_CAPTURE;
                        fcnt_d = 4'd1;
                    end
                end
            SQ_CAPTURE:
                if (fb)
                begin
                    fcnt_d = fcnt_q + 4'd1;
                    if ((fcnt_q >= act_cap_q[5:2] && fcnt_q != 4'd0)
                        || seqf_q + 4'd1 >= `SNAP_MAX_FRAMES)
                        seq_d = SQ_PREVIEW;
                end
            SQ_VIDEO, SQ_BATCH:
                if (ctx_cmd)
                    seq_d = SQ_PREVIEW;
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            seq_q <= SQ_PREVIEW;
            fcnt_q <= 4'd0;
            seqf_q <= 4'd0;
            act_cap_q <= 8'h00;
        end
        else
        begin
            seq_q <= seq_d;
            fcnt_q <= fcnt_d;
            seqf_q <= seqf_d;
            act_cap_q <= act_cap_d;
        end
    end

    // Exposure control.
    ae_phase_t ph_q, ph_d;
    logic [21:0] sum_q, sum_d, quo_q, quo_d;
    logic [12:0] wsum_q, wsum_d, den_q, den_d;
    logic [13:0] rem_q, rem_d, rem_s;
    logic [4:0] dcnt_q, dcnt_d;
    logic [7:0] filt_q, filt_d, pt_q, pt_d;
    logic [3:0] pa_q, pa_d;
    logic [4:0] pg_q, pg_d;
    logic [3:0] zx, zy;
    logic [2:0] w;
    logic [7:0] avg;
    logic signed [9:0] err, step;
    logic ae_run;
    logic [7:0] filt_n;
    assign zx = zone_of(px_q, win_q[2:0], full_q);
    assign zy = zone_of(py_q, win_q[5:3], full_q);
    assign w = weight_of(wmode_q, zx[2:0], zy[2:0]);
    assign rem_s = {rem_q[12:0], quo_q[21]};
    assign avg = (quo_q[21:8] != 14'd0) ? 8'hff : quo_q[7:0];
    assign ae_run = (seq_q == SQ_PREVIEW) || (seq_q == SQ_SETTLE)
        || (seq_q == SQ_VIDEO && act_cap_q[7]);
    assign step = $signed({2'b00, avg}) - $signed({2'b00, filt_q});
    assign filt_n = filt_q + 8'((step >>> speed_q));
    assign err = $signed({2'b00, filt_n}) - $signed({2'b00, target_q});

    always_comb
    begin
        ph_d = ph_q;
        sum_d = sum_q;
        wsum_d = wsum_q;
        quo_d = quo_q;
        rem_d = rem_q;
        den_d = den_q;
        dcnt_d = dcnt_q;
        filt_d = filt_q;
        pt_d = pt_q;
        pa_d = pa_q;
        pg_d = pg_q;
        if (active_q && zx[3] && zy[3])
        begin
            sum_d = sum_q + {11'd0, 11'(sensor_luma) * 11'(w)};
            wsum_d = wsum_q + {10'd0, w};
        end
        unique case (ph_q)
            AE_ACC:
                if (eof)
                begin
                    ph_d = AE_DIV;
                    quo_d = sum_d;
                    den_d = wsum_d;
                    rem_d = 14'd0;
                    dcnt_d = `DIV_STEPS;
                    sum_d = 22'd0;
                    wsum_d = 13'd0;
                end
            AE_DIV:
            begin
                if (rem_s >= {1'b0, den_q})
                begin
                    rem_d = rem_s - {1'b0, den_q};
                    quo_d = {quo_q[20:0], 1'b1};
                end
                else
                begin
                    rem_d = rem_s;
                    quo_d = {quo_q[20:0], 1'b0};
                end
                dcnt_d = dcnt_q - 5'd1;
                if (dcnt_q == 5'd1)
                    ph_d = AE_UPD;
            end
            AE_UPD:
            begin
                ph_d = AE_ACC;
                if (ae_run && den_q != 13'd0)
                begin
                    filt_d = filt_n;
                    if (err > $signed({2'b00, thresh_q}))
                    begin
                        if (pg_q > `DGAIN_UNITY)
                            pg_d = pg_q - 5'd1;
                        else if (pa_q > `AGAIN_RST)
                            pa_d = pa_q - 4'd1;
                        else if (pt_q >= `EXP_T_MIN + `AE_T_STEP)
                            pt_d = pt_q - `AE_T_STEP;
                    end
                    else if (err < -$signed({2'b00, thresh_q}))
                    begin
                        if (pt_q <= `EXP_T_MAX - `AE_T_STEP)
                            pt_d = pt_q + `AE_T_STEP;
                        else if (pa_q < `AGAIN_MAX)
                            pa_d = pa_q + 4'd1;
                        else if (pg_q < `DGAIN_MAX)
                            pg_d = pg_q + 5'd1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ph_q <= AE_ACC;
            sum_q <= 22'd0;
            wsum_q <= 13'd0;
            quo_q <= 22'd0;
            rem_q <= 14'd0;
            den_q <= 13'd0;
            dcnt_q <= 5'd0;
            filt_q <= `TARGET_RST;
            pt_q <= `EXP_T_RST;
            pa_q <= `AGAIN_RST;
            pg_q <= `DGAIN_UNITY;
        end
        else
        begin
            ph_q <= ph_d;
            sum_q <= sum_d;
            wsum_q <= wsum_d;
            quo_q <= quo_d;
            rem_q <= rem_d;
            den_q <= den_d;
            dcnt_q <= dcnt_d;
            filt_q <= filt_d;
            pt_q <= pt_d;
            pa_q <= pa_d;
            pg_q <= pg_d;
        end
    end

    // Frame generator and registered outputs.
    logic fs_d, pv_d, ctx_d, led_d, xen_d;
    logic [7:0] pd_d, et_d;
    logic [3:0] ag_d;
    logic [4:0] dg_d;
    logic [12:0] prod;
    logic is_b;
    logic first_px;
    assign is_b = (seq_d == SQ_CAPTURE) || (seq_d == SQ_VIDEO) || (seq_d == SQ_BATCH);
    assign first_px = active_q && px_q == 6'd0 && py_q == 6'd0;
    // The first pixel already uses the gain that its frame starts with.
    assign prod = sensor_luma * (first_px ? pg_q : digital_gain);

    always_comb
    begin
        active_d = active_q;
        px_d = px_q;
        py_d = py_q;
        bl_d = bl_q;
        full_d = full_q;
        ctx_d = lnk.ctx_b;
        et_d = exp_time;
        ag_d = analog_gain;
        dg_d = digital_gain;
        fs_d = first_px;
        pv_d = active_q;
        pd_d = (prod[12:4] > 9'h0ff) ? 8'hff : prod[11:4];
        led_d = (seq_q == SQ_SETTLE) || (seq_q == SQ_CAPTURE && flash_q[0] && flash_use);
        xen_d = lnk.ctx_b && seq_q == SQ_CAPTURE && flash_q[1] && flash_use;
        if (active_q)
        begin
            px_d = px_q + 6'd1;
            if (px_q == dim - 6'd1)
            begin
                px_d = 6'd0;
                py_d = py_q + 6'd1;
                if (py_q == dim - 6'd1)
                begin
                    active_d = 1'b0;
                    bl_d = 6'd0;
                end
            end
        end
        else if (fb)
        begin
            active_d = 1'b1;
            px_d = 6'd0;
            py_d = 6'd0;
            full_d = is_b && act_cap_d[6];
        end
        else
            bl_d = bl_q + 6'd1;
        // Context and exposure outputs move together with the frame start pulse.
        if (first_px)
        begin
            ctx_d = (seq_q == SQ_CAPTURE) || (seq_q == SQ_VIDEO) || (seq_q == SQ_BATCH);
            et_d = pt_q;
            ag_d = pa_q;
            dg_d = pg_q;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            active_q <= 1'b0;
            px_q <= 6'd0;
            py_q <= 6'd0;
            bl_q <= 6'd0;
            full_q <= 1'b0;
            lnk.ctx_b <= 1'b0;
            lnk.fs <= 1'b0;
            lnk.pvalid <= 1'b0;
            lnk.pdata <= 8'h00;
            lnk.cmd_ack <= 1'b0;
            led_flash <= 1'b0;
            xenon_strobe <= 1'b0;
            exp_time <= `EXP_T_RST;
            analog_gain <= `AGAIN_RST;
            digital_gain <= `DGAIN_UNITY;
            seq_busy <= 1'b0;
        end
        else
        begin
            active_q <= active_d;
            px_q <= px_d;
            py_q <= py_d;
            bl_q <= bl_d;
            full_q <= full_d;
            lnk.ctx_b <= ctx_d;
            lnk.fs <= fs_d;
            lnk.pvalid <= pv_d;
            lnk.pdata <= pd_d;
            lnk.cmd_ack <= ack_d;
            led_flash <= led_d;
            xenon_strobe <= xen_d;
            exp_time <= et_d;
            analog_gain <= ag_d;
            digital_gain <= dg_d;
            seq_busy <= seq_d != SQ_PREVIEW;
        end
    end
    assign sensor_read = active_q;
endmodule

// [rtl/capseq_host.sv]
// Host end: APB register slave that issues link commands and keeps a pixel ring.
`timescale 1ns/100ps
`include "capseq_defs.svh"
module capseq_host (
    input wire logic clk,
    input wire logic rst,
    capseq_if.host lnk,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    import capseq_pkg::*;

    logic [7:0] ring_q [0:(1 << `RING_AW) - 1];
    logic [`RING_AW-1:0] wp_q, wp_d, ridx_q, ridx_d;
    logic [15:0] frames_q, frames_d;
    logic cv_d, rdy_d, err_d, ring_we;
    cmd_op_t op_d;
    logic [15:0] cd_d;
    logic [31:0] rd_d;
    logic acc;
    assign acc = psel && penable && !pready;
    assign ring_we = lnk.pvalid && lnk.ctx_b;

    always_comb
    begin
        cv_d = lnk.cmd_valid && !lnk.cmd_ack;
        op_d = lnk.cmd_op;
        cd_d = lnk.cmd_data;
        wp_d = ring_we ? wp_q + 1'b1 : wp_q;
        ridx_d = ridx_q;
        frames_d = lnk.fs ? frames_q + 16'd1 : frames_q;
        rdy_d = acc;
        err_d = 1'b0;
        rd_d = 32'h0000_0000;
        if (acc)
        begin
            unique case (paddr)
                `A_CMD:
                    if (pwrite && !lnk.cmd_valid)
                    begin
                        cv_d = 1'b1;
                        op_d = cmd_op_t'(pwdata[`CMD_OP_LSB+2:`CMD_OP_LSB]);
                        cd_d = pwdata[15:0];
                    end
                    else if (pwrite)
                        err_d = 1'b1;
                    else
                        rd_d = {31'd0, lnk.cmd_valid};
                `A_STAT:
                    rd_d = {15'd0, lnk.ctx_b, frames_q};
                `A_RIDX:
                    if (pwrite)
                        ridx_d = pwdata[`RING_AW-1:0];
                    else
                        rd_d = {29'd0, ridx_q};
                `A_RDAT:
                    rd_d = {24'd0, ring_q[wp_q - ridx_q - 1'b1]};
                default:
                    err_d = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            lnk.cmd_valid <= 1'b0;
            lnk.cmd_op <= OP_CTX;
            lnk.cmd_data <= 16'h0000;
            wp_q <= '0;
            ridx_q <= '0;
            frames_q <= 16'h0000;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            for (int i = 0; i < (1 << `RING_AW); i++)
                ring_q[i] <= 8'h00;
        end
        else
        begin
            lnk.cmd_valid <= cv_d;
            lnk.cmd_op <= op_d;
            lnk.cmd_data <= cd_d;
            wp_q <= wp_d;
            ridx_q <= ridx_d;
            frames_q <= frames_d;
            prdata <= rd_d;
            pready <= rdy_d;
            pslverr <= err_d;
            if (ring_we)
                ring_q[wp_q] <= lnk.pdata;
        end
    end
endmodule

// [dv/capseq_checker.sv]
// Concurrent checks on the command and pixel link between both ends.
`timescale 1ns/100ps
module capseq_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic cmd_valid,
    input wire capseq_pkg::cmd_op_t cmd_op,
    input wire logic [15:0] cmd_data,
    input wire logic cmd_ack,
    input wire logic fs,
    input wire logic pvalid,
    input wire logic [7:0] pdata,
    input wire logic ctx_b
);
    import capseq_pkg::*;
    logic [11:0] run_q;
    logic [11:0] run_d;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Counts the pixels of the frame in flight.
    always_comb
    begin
        run_d = pvalid ? run_q + 12'h1 : 12'h0;
    end
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            run_q <= 12'h0;
        else
            run_q <= run_d;
    end
    ack_one_cycle_a: assert property (cmd_ack |=> !cmd_ack)
        else $error("ack longer than one cycle");
    ack_timing_a: assert property ($rose(cmd_valid) |=> cmd_ack)
        else $error("ack not one cycle after request");
    cmd_hold_a: assert property (cmd_valid && !cmd_ack |=>
        cmd_valid && $stable(cmd_op) && $stable(cmd_data)) else $error("command not held");
    cmd_drop_a: assert property (cmd_ack |=> !cmd_valid)
        else $error("request not dropped after ack");
    ctx_on_fs_a: assert property ($changed(ctx_b) |-> fs)
        else $error("context changed inside a frame");
    fs_pixel_a: assert property (fs |-> pvalid ##1 !fs)
        else $error("frame start without pixel");
    blank_gap_a: assert property ($fell(pvalid) |-> !pvalid [*8] ##[32:34] fs)
        else $error("frame gap wrong");
    preview_size_a: assert property (!ctx_b && $fell(pvalid) |-> run_q == 12'd576)
        else $error("preview frame size wrong");
    capture_size_a: assert property (ctx_b && $fell(pvalid) |->
        run_q == 12'd576 || run_q == 12'd2304) else $error("capture frame size wrong");
endmodule

// [dv/testbench.sv]
// Testbench joining the host and sensor ends through the link.
`timescale 1ns/100ps
module testbench;
    import capseq_pkg::*;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, er;
    logic sensor_read, led_flash, xenon_strobe, seq_busy, c, l, x;
    logic [7:0] paddr, sensor_luma, exp_time, exp_prev;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] analog_gain;
    logic [4:0] digital_gain;
    int err_total, total_checks, len;
    capseq_if capseq_if_inst ();
    capseq_dev capseq_dev_inst (.clk(clk), .rst(rst), .lnk(capseq_if_inst.dev),
        .sensor_luma(sensor_luma), .sensor_read(sensor_read), .led_flash(led_flash),
        .xenon_strobe(xenon_strobe), .exp_time(exp_time), .analog_gain(analog_gain),
        .digital_gain(digital_gain), .seq_busy(seq_busy));
    capseq_host capseq_host_inst (.clk(clk), .rst(rst), .lnk(capseq_if_inst.host),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    capseq_checker capseq_checker_inst (.clk(clk), .rst(rst),
        .cmd_valid(capseq_if_inst.cmd_valid), .cmd_op(capseq_if_inst.cmd_op),
        .cmd_data(capseq_if_inst.cmd_data), .cmd_ack(capseq_if_inst.cmd_ack),
        .fs(capseq_if_inst.fs), .pvalid(capseq_if_inst.pvalid), .pdata(capseq_if_inst.pdata),
        .ctx_b(capseq_if_inst.ctx_b));
    task automatic final_report();
        if (err_total == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50)
        begin
            err_total++;
            final_report();
        end
    endtask
    // Writes a link command and polls until the host no longer holds it.
    task automatic cmd(input cmd_op_t op, input logic [15:0] d);
        apb(1'b1, 8'h00, {13'h0, op, d});
        check("cmd_err", 32'(er), 32'h0);
        for (int i = 0; i < 10; i++)
        begin
            apb(1'b0, 8'h00, 32'h0);
            if (rd[0] === 1'b0)
                break;
        end
        check("cmd_pending", 32'(rd[0]), 32'h0);
    endtask
    // Waits for the next frame start and counts its pixels.
    task automatic frame();
        int n;
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end while (capseq_if_inst.fs !== 1'b1 && n < 3000);
        if (n >= 3000)
        begin
            err_total++;
            final_report();
        end
        c = capseq_if_inst.ctx_b;
        l = led_flash;
        x = 1'b0;
        len = 0;
        while (capseq_if_inst.pvalid === 1'b1 && len < 3000)
        begin
            len++;
            @(negedge clk);
            if (len == 2)
                x = xenon_strobe;
        end
    endtask
    task automatic t_reset();
        logic [31:0] s;
        check("exp_rst", 32'(exp_time), 32'd100);
        check("again_rst", 32'(analog_gain), 32'd1);
        check("dgain_rst", 32'(digital_gain), 32'h10);
        apb(1'b0, 8'h10, 32'h0);
        check("unmapped", 32'(er), 32'h1);
        frame();
        apb(1'b0, 8'h04, 32'h0);
        s = rd;
        frame();
        check("prv_len", 32'(len), 32'd576);
        apb(1'b0, 8'h04, 32'h0);
        check("stat", rd[16:0], {1'b0, s[15:0] + 16'h1});
    endtask
    task automatic t_exposure();
        logic [7:0] e;
        cmd(OP_WINDOW, 16'h0009);
        cmd(OP_WEIGHT, 16'h0002);
        cmd(OP_TARGET, 16'h0080);
        @(posedge clk);
        sensor_luma <= 8'hff;
        repeat (10) frame();
        check("bright", 32'(exp_time < 8'd100), 32'h1);
        e = exp_time;
        @(posedge clk);
        sensor_luma <= 8'h00;
        repeat (10) frame();
        check("dark", 32'(exp_time > e), 32'h1);
        @(posedge clk);
        sensor_luma <= 8'h80;
    endtask
    task automatic t_snapshot();
        int i, capn, ledn;
        capn = 0;
        ledn = 0;
        cmd(OP_FLASH, 16'h0017);
        cmd(OP_CAPCFG, 16'h0048);
        cmd(OP_CTX, 16'h0);
        check("snap_busy", 32'(seq_busy), 32'h1);
        for (i = 0; i < 12; i++)
        begin
            frame();
            if (c === 1'b1)
            begin
                capn++;
                check("cap_len", 32'(len), 32'd2304);
                check("xenon", 32'(x), 32'h1);
            end
            else if (capn > 0)
                break;
            else if (l === 1'b1)
                ledn++;
        end
        check("cap_frames", 32'(capn), 32'd2);
        check("settle", 32'(ledn), 32'd2);
        check("snap_total", 32'(i <= 10), 32'h1);
        check("back_prv", 32'({c, l, seq_busy}), 32'h0);
    endtask
    task automatic t_stream(input logic [1:0] mode);
        cmd(OP_CAPCFG, {14'h2, mode});
        cmd(OP_CTX, 16'h0);
        repeat (3)
        begin
            frame();
            check("stream_ctx", 32'({c, seq_busy}), 32'h3);
            check("stream_len", 32'(len), 32'd576);
        end
        apb(1'b1, 8'h08, 32'h3);
        apb(1'b0, 8'h0c, 32'h0);
        check("ring", rd, 32'(digital_gain) << 3);
        cmd(OP_CTX, 16'h0);
        frame();
        check("exit", 32'({c, seq_busy}), 32'h0);
    endtask
    // Exposure time may move only together with a frame start.
    always @(negedge clk)
    begin
        if (!rst && exp_time !== exp_prev)
            check("exp_fs", 32'(capseq_if_inst.fs), 32'h1);
        exp_prev = exp_time;
    end
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial
    begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        sensor_luma = 8'h80;
        err_total = 0;
        total_checks = 0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_exposure();
        t_snapshot();
        t_stream(2'd1);
        t_stream(2'd2);
        final_report();
    end
endmodule
